// ---- hdl/actc_pkg.sv ----
/*
 constants for the converter channel and trigger control block.
 assumes a single 40 MHz clock domain and an analog core outside.
*/
// Notes on behaviour
// - codes 0..23 pick external inputs; 29 high reference, 30 low reference.
// - reserved codes 24, 25, 28 give an undefined result.
// - code 26 selects the temperature sensor, code 27 the bandgap.
// - conversion clock is bus, bus/2, local async or alternate clock.
// - alternate clock comes from the clock unit reference clock output.
// - conversions start by software write or hardware trigger.
// - with hardware trigger selected, counter equal to modulo triggers.
// - counter match triggers regardless of counter interrupt enable.
// - hardware trigger works in run, wait and stop3.
// - one interrupt request line for all conditions.
// - clock gate bit set by reset; clearing it stops the converter clock.
// - results unsigned right-justified in 12, 10 or 8 bits.
// - single or continuous; single returns to idle by itself.
// - optional compare less-than or greater-or-equal gates completion.
// - successive approximation resolves twelve bits.
// - converter keeps working in wait and stop3.
// - control write aborts; it restarts only with channel not all ones, hardware trigger not selected and clock gate bit set.
// - complete flag sets on completion; clears on control write or low read.
// - channel all ones turns converter off without a further conversion.
// - continuous plus hardware trigger runs back to back after one event.
package actc_pkg;
	localparam int CH_W = 5;
	localparam int RES_W = 12;
	localparam logic [4:0] CH_LAST_EXT = 5'h17;
	localparam logic [4:0] CH_RSV0 = 5'h18;
	localparam logic [4:0] CH_RSV1 = 5'h19;
	localparam logic [4:0] CH_TEMP = 5'h1a;
	localparam logic [4:0] CH_BANDGAP = 5'h1b;
	localparam logic [4:0] CH_RSV2 = 5'h1c;
	localparam logic [4:0] CH_VREFH = 5'h1d;
	localparam logic [4:0] CH_VREFL = 5'h1e;
	localparam logic [4:0] CH_OFF = 5'h1f;
	localparam logic [1:0] CLK_BUS = 2'h0;
	localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
	localparam logic [1:0] CLK_ALT = 2'h2;
	localparam logic [1:0] CLK_ASYNC = 2'h3;
	localparam logic [1:0] MODE_8 = 2'h0;
	localparam logic [1:0] MODE_12 = 2'h1;
	localparam logic [1:0] MODE_10 = 2'h2;
	localparam logic [3:0] SAR_BITS = 4'hc;
	localparam logic [3:0] SAMPLE_TICKS = 4'h4;
	typedef enum logic [1:0] {
		ACTC_IDLE = 2'b00,
		ACTC_SAMPLE = 2'b01,
		ACTC_CONVERT = 2'b10
	} actc_state_t;
endpackage

// ---- hdl/actc_clk_tick.sv ----
/*
 conversion clock tick generator.
 assumes the async and alternate clocks are slow versus the bus clock.
*/
`timescale 1ns/10ps
module actc_clk_tick
	import actc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic run,
	input wire logic [1:0] clk_sel,
	input wire logic local_async_conv_clock,
	input wire logic alternate_conv_clock,
	output logic tick
);
	// ****************
	// synchronisers
	// ****************
	logic [1:0] async_s_q;
	logic [1:0] alt_s_q;
	logic async_last_q;
	logic alt_last_q;
	logic div_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			async_s_q <= 2'h0;
			alt_s_q <= 2'h0;
			async_last_q <= 1'b0;
			alt_last_q <= 1'b0;
			div_q <= 1'b0;
		end else begin
			async_s_q <= {async_s_q[0], local_async_conv_clock};
			alt_s_q <= {alt_s_q[0], alternate_conv_clock};
			async_last_q <= async_s_q[1];
			alt_last_q <= alt_s_q[1];
			div_q <= run ? ~div_q : 1'b0;
		end
	end
	wire async_rise = async_s_q[1] & ~async_last_q;
	wire alt_rise = alt_s_q[1] & ~alt_last_q;
	assign tick = (clk_sel == CLK_BUS) ? run :
		(clk_sel == CLK_BUS_DIV2) ? (run & div_q) :
		(clk_sel == CLK_ALT) ? (run & alt_rise) : (run & async_rise);
endmodule

// ---- hdl/actc_top.sv ----
/*
 channel decode, trigger, sequencing, compare and flag for a 12-bit
 successive-approximation converter.
 assumes the analog comparator returns a level per trial, and that
 control writes and low-byte reads arrive as one-cycle strobes.
*/
`timescale 1ns/10ps
module actc_top
	import actc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ctrl_write,
	input wire logic [4:0] channel_select_field,
	input wire logic continuous_conversion_enable,
	input wire logic int_enable,
	input wire logic hardware_trigger_select,
	input wire logic compare_function_enable,
	input wire logic compare_greater_equal,
	input wire logic [11:0] compare_value,
	input wire logic [1:0] mode_sel,
	input wire logic [1:0] clk_sel,
	input wire logic clock_gate_write,
	input wire logic clock_gate_value,
	input wire logic result_low_read,
	input wire logic [15:0] rtc_count_value,
	input wire logic [15:0] rtc_modulo_value,
	input wire logic local_async_conv_clock,
	input wire logic clock_unit_ext_reference_clock,
	input wire logic comparator_out,
	output logic [23:0] ext_input_sel,
	output logic temp_sensor_sel,
	output logic bandgap_sel,
	output logic vrefh_sel,
	output logic vrefl_sel,
	output logic reserved_sel,
	output logic [11:0] dac_trial,
	output logic sample_en,
	output logic [11:0] result,
	output logic conversion_complete_flag,
	output logic conv_active,
	output logic irq,
	output logic peripheral_clock_gate_one
);
	// ****************
	// state
	// ****************
	actc_state_t state_q, state_d;
	logic [4:0] chan_q;
	logic cont_q;
	logic hwt_q;
	logic gate_q;
	logic conversion_complete_flag_q;
	logic [11:0] sar_q;
	logic [3:0] bit_q;
	logic [3:0] samp_q;
	logic [11:0] result_q;
	logic [1:0] match_q;
	logic [23:0] ext_q;
	logic [4:0] sel_q;
	logic irq_q;

	function automatic logic [11:0] fmt(input logic [11:0] v, input logic [1:0] m);
		logic [11:0] r;
		r = v;
		if (m == MODE_8) begin
			r = {4'h0, v[11:4]};
		end else if (m == MODE_10) begin
			r = {2'h0, v[11:2]};
		end
		return r;
	endfunction

	// ****************
	// decode
	// ****************
	wire ch_off = (chan_q == CH_OFF);
	wire running = gate_q & ~ch_off;
	wire [4:0] sel_ch = ctrl_write ? channel_select_field : chan_q;
	wire is_ext = (sel_ch <= CH_LAST_EXT);
	wire [23:0] ext_d = is_ext ? (24'h000001 << sel_ch) : 24'h000000;
	wire [4:0] sel_d = {(sel_ch == CH_RSV0) | (sel_ch == CH_RSV1) | (sel_ch == CH_RSV2),
		sel_ch == CH_VREFL, sel_ch == CH_VREFH,
		sel_ch == CH_BANDGAP, sel_ch == CH_TEMP};
	// bandgap buffer power is enabled by software elsewhere

	wire match_now = (rtc_count_value == rtc_modulo_value);
	wire hw_trigger_event = hwt_q & match_q[0] & ~match_q[1];
	wire tick;
	actc_clk_tick u_tick (
		.clock(clock),
		.rst(rst),
		.run(running && state_q != ACTC_IDLE),
		.clk_sel(clk_sel),
		.local_async_conv_clock(local_async_conv_clock),
		.alternate_conv_clock(clock_unit_ext_reference_clock),
		.tick(tick)
	);

	// gated clock or trigger mode: a write only aborts
	wire sw_start = ctrl_write & gate_q & (channel_select_field != CH_OFF)
		& ~hardware_trigger_select;
	wire hw_start = ~ctrl_write & running & hw_trigger_event & (state_q == ACTC_IDLE);
	wire last_bit = (bit_q == 4'h0);
	wire [11:0] sar_trial = sar_q | (12'h001 << bit_q);
	wire [11:0] sar_kept = comparator_out ? sar_trial : sar_q;
	wire done = running & tick & (state_q == ACTC_CONVERT) & last_bit;
	wire [11:0] fmt_res = fmt(sar_kept, mode_sel);
	wire cmp_true = compare_greater_equal ? (fmt_res >= compare_value) : (fmt_res < compare_value);
	wire conversion_complete_flag_set = done & (~compare_function_enable | cmp_true);

	always_comb begin
		state_d = state_q;
		if (ctrl_write) begin
			state_d = sw_start ? ACTC_SAMPLE : ACTC_IDLE;
		end else if (!running) begin
			state_d = ACTC_IDLE;
		end else if (hw_start) begin
			state_d = ACTC_SAMPLE;
		end else if (tick) begin
			unique case (state_q)
				ACTC_IDLE: begin
					state_d = ACTC_IDLE;
				end
				ACTC_SAMPLE: begin
					state_d = (samp_q == 4'h0) ? ACTC_CONVERT : ACTC_SAMPLE;
				end
				ACTC_CONVERT: begin
					state_d = !last_bit ? ACTC_CONVERT : cont_q ? ACTC_SAMPLE : ACTC_IDLE;
				end
				default: begin
					state_d = ACTC_IDLE;
				end
			endcase
		end
	end

	// ****************
	// registers
	// ****************
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ACTC_IDLE;
			chan_q <= CH_OFF;
			cont_q <= 1'b0;
			hwt_q <= 1'b0;
			gate_q <= 1'b1;
			match_q <= 2'h0;
		end else begin
			state_q <= state_d;
			match_q <= {match_q[0], match_now};
			if (ctrl_write) begin
				chan_q <= channel_select_field;
				cont_q <= continuous_conversion_enable;
				hwt_q <= hardware_trigger_select;
			end
			if (clock_gate_write) begin
				gate_q <= clock_gate_value;
			end
		end
	end

	// a restart during sampling reloads too
	wire sar_load = (state_d == ACTC_SAMPLE) & ((state_q != ACTC_SAMPLE) | ctrl_write);
	wire sar_step = tick & (state_q == ACTC_CONVERT);
	wire sar_wrap = sar_load | (sar_step & last_bit);
	wire [11:0] sar_d = sar_wrap ? 12'h000 : sar_step ? sar_kept : sar_q;
	wire [3:0] bit_d = sar_wrap ? SAR_BITS - 4'h1 : sar_step ? bit_q - 4'h1 : bit_q;
	// trial shown is the one judged at the next tick
	wire [11:0] trial_d = sar_d | (12'h001 << bit_d);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sar_q <= 12'h000;
			bit_q <= 4'h0;
			samp_q <= 4'h0;
		end else begin
			sar_q <= sar_d;
			bit_q <= bit_d;
			if (sar_load || sar_step) begin
				samp_q <= SAMPLE_TICKS - 4'h1;
			end else if (tick && state_q == ACTC_SAMPLE) begin
				samp_q <= samp_q - 4'h1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			result_q <= 12'h000;
			conversion_complete_flag_q <= 1'b0;
			irq_q <= 1'b0;
			ext_q <= 24'h000000;
			sel_q <= 5'h00;
		end else begin
			ext_q <= ext_d;
			sel_q <= sel_d;
			if (conversion_complete_flag_set) begin
				result_q <= fmt_res;
			end
			// set wins over clear
			conversion_complete_flag_q <= conversion_complete_flag_set | (conversion_complete_flag_q & ~ctrl_write & ~result_low_read);
			irq_q <= int_enable & (conversion_complete_flag_set | (conversion_complete_flag_q & ~ctrl_write & ~result_low_read));
		end
	end

	// ****************
	// outputs
	// ****************
	logic [11:0] trial_q;
	logic samp_en_q;
	logic active_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trial_q <= 12'h000;
			samp_en_q <= 1'b0;
			active_q <= 1'b0;
		end else begin
			trial_q <= (state_d == ACTC_CONVERT) ? trial_d : 12'h000;
			samp_en_q <= (state_d == ACTC_SAMPLE);
			active_q <= (state_d != ACTC_IDLE);
		end
	end
	assign ext_input_sel = ext_q;
	assign temp_sensor_sel = sel_q[0];
	assign bandgap_sel = sel_q[1];
	assign vrefh_sel = sel_q[2];
	assign vrefl_sel = sel_q[3];
	assign reserved_sel = sel_q[4];
	assign dac_trial = trial_q;
	assign sample_en = samp_en_q;
	assign result = result_q;
	assign conversion_complete_flag = conversion_complete_flag_q;
	assign conv_active = active_q;
	assign irq = irq_q;
	assign peripheral_clock_gate_one = gate_q;
endmodule

// ---- tb/actc_top_chk.sv ----
/*
 port assertions for the channel and trigger control block.
 assumes it is bound onto actc_top; one clock domain.
*/
`timescale 1ns/10ps
module actc_top_chk
	import actc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic ctrl_write,
	input wire logic [4:0] channel_select_field,
	input wire logic hardware_trigger_select,
	input wire logic int_enable,
	input wire logic [1:0] mode_sel,
	input wire logic clock_gate_write,
	input wire logic clock_gate_value,
	input wire logic result_low_read,
	input wire logic sample_en,
	input wire logic conv_active,
	input wire logic irq,
	input wire logic conversion_complete_flag,
	input wire logic [11:0] result,
	input wire logic peripheral_clock_gate_one
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	// ********************
	// assertions
	// ********************
	a_off_stays_idle: assert property (ctrl_write && channel_select_field == CH_OFF |=> !conv_active)
		else $error("converter ran with channel off");
	a_write_starts_conv: assert property (ctrl_write && channel_select_field != CH_OFF
		&& !hardware_trigger_select && peripheral_clock_gate_one && !clock_gate_write
		|=> sample_en && conv_active)
		else $error("write did not start a conversion");
	a_hw_write_waits: assert property (ctrl_write && hardware_trigger_select |=> !conv_active)
		else $error("write started a conversion in trigger mode");
	a_irq_needs_enable: assert property (!int_enable ##1 !int_enable |-> !irq)
		else $error("interrupt raised while disabled");
	a_flag_clears: assert property ((ctrl_write || result_low_read) && !conv_active
		|=> !conversion_complete_flag)
		else $error("complete flag not cleared");
	a_gate_follows: assert property (clock_gate_write
		|=> peripheral_clock_gate_one == $past(clock_gate_value))
		else $error("clock gate bit not written");
	a_gate_after_reset: assert property ($fell(rst) |-> peripheral_clock_gate_one)
		else $error("clock gate bit clear after reset");
	a_result_justified: assert property ($rose(conversion_complete_flag)
		|-> ($past(mode_sel) != MODE_8 || result[11:8] == 4'h0)
		&& ($past(mode_sel) != MODE_10 || result[11:10] == 2'h0))
		else $error("result not right justified");
	c_done: cover property ($rose(conversion_complete_flag));
	c_irq: cover property (irq);
	c_hw_write: cover property (ctrl_write && hardware_trigger_select);
	c_back_to_back: cover property ($rose(conversion_complete_flag) && sample_en);
endmodule

// ---- tb/actc_analog_model.sv ----
/*
 analog inputs and real-time counter model.
 assumes the bench sets the input level as a 12-bit target.
*/
`timescale 1ns/10ps
module actc_analog_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic [11:0] dac_trial,
	input wire logic [11:0] target,
	input wire logic [15:0] rtc_modulo_value,
	output logic comparator_out,
	output logic [15:0] rtc_count_value,
	output logic local_async_conv_clock,
	output logic clock_unit_ext_reference_clock
);
	// ********************
	// analog side
	// ********************
	// bandgap buffer taken as enabled by software
	assign comparator_out = dac_trial <= target;
	initial begin
		local_async_conv_clock = 1'b0;
		clock_unit_ext_reference_clock = 1'b0;
	end
	always #70 local_async_conv_clock = ~local_async_conv_clock;
	always #95 clock_unit_ext_reference_clock = ~clock_unit_ext_reference_clock;
	// ********************
	// counter, no interrupt enable needed
	// ********************
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			rtc_count_value <= 16'h0000;
		else if (rtc_count_value >= rtc_modulo_value)
			rtc_count_value <= 16'h0000;
		else
			rtc_count_value <= rtc_count_value + 16'h0001;
	end
endmodule

// ---- tb/actc_top_test.sv ----
/*
 self-checking bench for actc_top.
 assumes the analog model and the checker are compiled with it.
*/
`timescale 1ns/10ps
module actc_top_test;
	import actc_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ctrl_write = 1'b0;
	logic [4:0] channel_select_field = CH_OFF;
	logic continuous_conversion_enable = 1'b0;
	logic int_enable = 1'b0;
	logic hardware_trigger_select = 1'b0;
	logic compare_function_enable = 1'b0;
	logic compare_greater_equal = 1'b0;
	logic [11:0] compare_value = 12'h000;
	logic [1:0] mode_sel = MODE_12;
	logic [1:0] clk_sel = CLK_BUS;
	logic clock_gate_write = 1'b0;
	logic clock_gate_value = 1'b1;
	logic result_low_read = 1'b0;
	logic [15:0] rtc_modulo_value = 16'h0040;
	logic [11:0] target = 12'h000;
	logic [15:0] rtc_count_value;
	logic local_async_conv_clock, clock_unit_ext_reference_clock, comparator_out, sample_en;
	logic [23:0] ext_input_sel;
	logic temp_sensor_sel, bandgap_sel, vrefh_sel, vrefl_sel, reserved_sel, flag_q;
	logic [11:0] dac_trial, result;
	logic conversion_complete_flag, conv_active, irq, peripheral_clock_gate_one;
	logic [12:0] exp_q[$];
	logic [12:0] e;
	int n_fail = 0;
	int samples_checked = 0;
	int seed = 32'h3bd3;
	always #12.5 clock = ~clock;
	actc_top DUT (.*);
	actc_analog_model u_model (.*);
	// ********************
	// tasks
	// ********************
	task automatic chk(input string what, input logic [28:0] exp, input logic [28:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_res(input logic [11:0] exp);
		chk("result", {17'h0, exp}, {17'h0, result});
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic start(input logic [4:0] ch, input logic hw);
		channel_select_field = ch;
		hardware_trigger_select = hw;
		ctrl_write = 1'b1;
		tick(1);
		ctrl_write = 1'b0;
	endtask
	task automatic wait_done;
		for (int k = 0; k < 3000 && conversion_complete_flag !== 1'b1; k++)
			tick(1);
		chk("done", 29'h1, {28'h0, conversion_complete_flag});
		tick(1);
	endtask
	task automatic pulse_read;
		result_low_read = 1'b1;
		tick(1);
		result_low_read = 1'b0;
	endtask
	task automatic gate(input logic v);
		clock_gate_value = v;
		clock_gate_write = 1'b1;
		tick(1);
		clock_gate_write = 1'b0;
	endtask
	task automatic convert(input logic [4:0] ch, input logic hw);
		logic [28:0] sel;
		logic rsv;
		target = 12'($random(seed));
		mode_sel = 2'($unsigned($random(seed)) % 3);
		int_enable = 1'($random(seed));
		rsv = ch == CH_RSV0 || ch == CH_RSV1 || ch == CH_RSV2;
		sel = rsv ? 29'h1 : ch <= CH_LAST_EXT ? 29'h20 << ch
			: 29'h10 >> (ch - CH_TEMP - 5'(ch > CH_RSV2));
		exp_q.push_back({rsv, mode_sel == MODE_8 ? {4'h0, target[11:4]}
			: mode_sel == MODE_10 ? {2'h0, target[11:2]} : target});
		start(ch, hw);
		wait_done;
		chk("irq", {28'h0, int_enable}, {28'h0, irq});
		chk("select", sel, {ext_input_sel, temp_sensor_sel, bandgap_sel, vrefh_sel,
			vrefl_sel, reserved_sel});
		pulse_read;
		tick(1);
		chk("idle", 29'h0, {27'h0, conversion_complete_flag, conv_active});
	endtask
	// ********************
	// result watcher
	// ********************
	always @(negedge clock) begin
		flag_q <= conversion_complete_flag;
		if (!rst && conversion_complete_flag === 1'b1 && flag_q === 1'b0) begin
			chk("pending", 29'h1, 29'(exp_q.size() > 0));
			e = exp_q.pop_front();
			if (e[12] === 1'b0)
				chk_res(e[11:0]);
		end
	end
	// ********************
	// tests
	// ********************
	initial begin
		tick(4);
		rst = 1'b0;
		for (int c = 0; c < 31; c++) begin
			clk_sel = 2'(c);
			convert(5'(c), 1'b0);
		end
		$display("channel sweep done");
		clk_sel = CLK_BUS;
		start(5'h03, 1'b0);
		tick(6);
		convert(5'h05, 1'b0);
		$display("abort test done");
		start(CH_OFF, 1'b0);
		tick(3);
		chk("off", 29'h0, {28'h0, conv_active});
		gate(1'b0);
		start(5'h02, 1'b0);
		tick(20);
		chk("gated", 29'h0, {27'h0, peripheral_clock_gate_one, conv_active});
		gate(1'b1);
		$display("gate test done");
		convert(5'h07, 1'b1);
		start(CH_OFF, 1'b0);
		tick(2);
		chk("left", 29'h0, 29'(exp_q.size()));
		$display("trigger test done");
		compare_function_enable = 1'b1;
		compare_greater_equal = 1'b1;
		compare_value = 12'h000;
		convert(5'h04, 1'b0);
		mode_sel = MODE_12;
		target = 12'($random(seed));
		compare_greater_equal = 1'b0;
		compare_value = target;
		start(5'h04, 1'b0);
		tick(40);
		chk("compare", 29'h0, {27'h0, conversion_complete_flag, conv_active});
		compare_function_enable = 1'b0;
		$display("compare test done");
		continuous_conversion_enable = 1'b1;
		target = 12'($random(seed));
		exp_q.push_back({1'b0, target});
		exp_q.push_back({1'b0, target});
		start(5'h09, 1'b1);
		wait_done;
		pulse_read;
		wait_done;
		start(CH_OFF, 1'b0);
		tick(40);
		chk("stopped", 29'h0, {28'h0, conv_active});
		chk("queue", 29'h0, 29'(exp_q.size()));
		continuous_conversion_enable = 1'b0;
		$display("continuous test done");
		give_verdict;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		give_verdict;
	end
endmodule
bind actc_top actc_top_chk u_chk (.*);
